/* File: design/tw8_pkg.sv */
// Purpose: Shared constants and types for the 8-bit timer waveform output block
// Assumes: Wishbone byte addresses, registers in byte lane 0 of a 32-bit word
// Notes: Register offsets, field positions and mode codes used by the logic are named here
package tw8_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] TW8_OFS_CTRL = 8'h00;
   localparam logic [7:0] TW8_OFS_COUNT = 8'h04;
   localparam logic [7:0] TW8_OFS_COMPARE = 8'h08;
   localparam logic [7:0] TW8_OFS_FLAGS = 8'h0c;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int TW8_CTRL_FORCE_BIT = 7;
   localparam int TW8_CTRL_WGM_HI_BIT = 6;
   localparam int TW8_CTRL_COM_HI_BIT = 5;
   localparam int TW8_CTRL_COM_LO_BIT = 4;
   localparam int TW8_CTRL_WGM_LO_BIT = 3;
   localparam int TW8_FLAG_OVF_BIT = 0;
   localparam int TW8_FLAG_CMP_BIT = 1;
   localparam int TW8_FLAG_STATE_BIT = 2;

   // ************************************************************
   // Values
   // ************************************************************
   localparam logic [7:0] TW8_BOTTOM = 8'h00;
   localparam logic [7:0] TW8_MAX = 8'hff;
   localparam logic [7:0] TW8_COUNT_RST = 8'h00;
   localparam logic [7:0] TW8_COMPARE_RST = 8'h00;
   localparam logic TW8_STATE_RST = 1'h0;
   localparam logic [31:0] TW8_READ_ZERO = 32'h0000_0000;

   // Waveform generation modes
   localparam logic [1:0] TW8_WGM_NORMAL = 2'h0;
   localparam logic [1:0] TW8_WGM_PHASE = 2'h1;
   localparam logic [1:0] TW8_WGM_CTC = 2'h2;
   localparam logic [1:0] TW8_WGM_FAST = 2'h3;

   // Compare output modes
   localparam logic [1:0] TW8_COM_OFF = 2'h0;
   localparam logic [1:0] TW8_COM_TOGGLE = 2'h1;
   localparam logic [1:0] TW8_COM_CLEAR = 2'h2;
   localparam logic [1:0] TW8_COM_SET = 2'h3;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic [1:0] wave_gen_mode;
      logic [1:0] cmp_out_mode;
   } tw8_ctrl_t;

   typedef struct packed {
      logic match;
      logic bottom;
      logic force_cmp;
   } tw8_evt_t;

endpackage : tw8_pkg

/* File: design/tw8_wave_out.sv */
// Purpose: Output-compare state register and port pin override
// Assumes: Events arrive as one-cycle pulses on clk
// Notes: Pin outputs are registered and follow the state without extra lag
`timescale 1ns/10ps
`default_nettype none
module tw8_wave_out (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Control and events
   input wire tw8_pkg::tw8_ctrl_t ctrl,
   input wire tw8_pkg::tw8_evt_t evt,
   // General port
   input wire logic port_out_value,
   input wire logic pin_direction_bit,
   // Results
   output logic cmp_out_state,
   output logic pin_out,
   output logic pin_oe
);

   logic next_cmp_out_state;
   logic is_fast;

   // ************************************************************
   // Next state
   // ************************************************************
   // Bottom action wins over a match in the same tick, giving a steady level at compare = MAX
   always_comb begin
      is_fast = (ctrl.wave_gen_mode == tw8_pkg::TW8_WGM_FAST);
      next_cmp_out_state = cmp_out_state;
      if (evt.match || evt.force_cmp) begin
         case (ctrl.cmp_out_mode)
            tw8_pkg::TW8_COM_OFF: next_cmp_out_state = cmp_out_state; // see [RULE_04]
            tw8_pkg::TW8_COM_TOGGLE: next_cmp_out_state = ~cmp_out_state; // see [RULE_12]
            tw8_pkg::TW8_COM_CLEAR: next_cmp_out_state = 1'b0; // see [RULE_16]
            tw8_pkg::TW8_COM_SET: next_cmp_out_state = 1'b1; // see [RULE_16]
            default: next_cmp_out_state = cmp_out_state;
         endcase
      end
      if (evt.bottom && is_fast) begin
         case (ctrl.cmp_out_mode)
            tw8_pkg::TW8_COM_CLEAR: next_cmp_out_state = 1'b1; // see [RULE_16]
            tw8_pkg::TW8_COM_SET: next_cmp_out_state = 1'b0; // see [RULE_16]
            default: next_cmp_out_state = next_cmp_out_state; // see [RULE_18]
         endcase
      end
   end

   // State register, cleared by system reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmp_out_state <= tw8_pkg::TW8_STATE_RST; // see [RULE_01]
      end else begin
         cmp_out_state <= next_cmp_out_state;
      end
   end

   // ************************************************************
   // Pin override
   // ************************************************************
   // Override ignores the waveform mode; direction stays with the port bit
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end else begin
         pin_out <= (ctrl.cmp_out_mode != tw8_pkg::TW8_COM_OFF) ? next_cmp_out_state : port_out_value; // see [RULE_02]
         pin_oe <= pin_direction_bit; // see [RULE_03]
      end
   end

endmodule : tw8_wave_out
`default_nettype wire

/* File: design/tw8_timer.sv */
// Purpose: 8-bit timer counter with compare, flags and waveform output, Wishbone slave
// Assumes: timer_tick is a one-cycle enable from same-clock prescaler logic
// Notes: Phase-correct mode counts as normal mode here; its dual slope is not built
//        Counter writes hide a match on the next tick
//        Force is ignored in PWM modes
//        Flag sets win over same-cycle clears
//
// Operation
// [RULE_01] Reset clears output-compare state to zero
// [RULE_02] Nonzero output mode overrides port output value
// [RULE_03] Direction bit keeps pin direction during override
// [RULE_04] Output mode zero leaves state unchanged
// [RULE_05] New output mode acts at next match
// [RULE_06] Only waveform mode selects the count sequence
// [RULE_07] Mode 0 counts up, wraps, never clears
// [RULE_08] Normal mode overflow flag set at zero
// [RULE_09] Counter writable anytime in normal mode
// [RULE_10] Mode 2 clears counter on compare match
// [RULE_11] Clear-on-compare compare register not buffered
// [RULE_12] Output mode 1 toggles state each match
// [RULE_13] Clear-on-compare overflow set at MAX wrap
// [RULE_14] Clear-on-compare raises compare flag at top
// [RULE_15] Mode 3 counts bottom to MAX, wraps
// [RULE_16] Fast PWM mode 2 non-inverting, 3 inverting
// [RULE_17] Fast PWM overflow flag set reaching MAX
// [RULE_18] Compare extremes give spike or steady level
// [RULE_19] Fast PWM compare writes go to buffer
// [RULE_20] Buffer loads active compare only at top
// [RULE_21] Mode field is control bits 6 and 3
// [RULE_22] Match sets compare flag next timer tick
// [RULE_23] Counter write blocks matches next tick
// [RULE_24] I/O clock registers, tick is enable
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module tw8_timer #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Timer clock enable
   input wire logic timer_tick,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Interrupt service clears
   input wire logic ovf_service_clr,
   input wire logic cmp_service_clr,
   // Flags
   output logic overflow_flag,
   output logic compare_flag,
   // General port pin
   input wire logic port_out_value,
   input wire logic pin_direction_bit,
   output logic cmp_out_state,
   output logic pin_out,
   output logic pin_oe
);

   // ************************************************************
   // Elaboration checks
   // ************************************************************
   // The map needs byte offsets up to the flags register
   if (ADDR_W < 4) begin : g_bad_addr
      $error("ADDR_W must be at least 4");
   end

   // Control and flag fields must sit in byte lane 0, the only lane decoded
   if (tw8_pkg::TW8_CTRL_FORCE_BIT >= $bits(tw8_pkg::TW8_MAX)) begin : g_bad_field
      $error("control fields must sit in byte lane 0");
   end

   // ************************************************************
   // Helpers
   // ************************************************************
   // Modes with double-buffered compare and no force strobe
   function automatic logic is_pwm(input logic [1:0] mode);
      is_pwm = (mode == tw8_pkg::TW8_WGM_FAST) || (mode == tw8_pkg::TW8_WGM_PHASE);
   endfunction : is_pwm

   // Register select on the low byte address
   function automatic logic hit(input logic [ADDR_W-1:0] adr, input logic [7:0] ofs);
      hit = (adr == ADDR_W'(ofs));
   endfunction : hit

   // ************************************************************
   // Declarations
   // ************************************************************
   // State and carriers
   tw8_pkg::tw8_ctrl_t ctrl;
   tw8_pkg::tw8_evt_t evt;
   logic [7:0] count_value;
   logic [7:0] compare_value;
   logic [7:0] compare_buf;
   logic match_block;
   logic force_pending;

   // Bus decode
   logic bus_req;
   logic wr_en;
   logic wr_ctrl;
   logic wr_count;
   logic wr_compare;
   logic wr_flags;
   logic [1:0] wdat_mode;

   // Compare and limits
   logic raw_match;
   logic match_evt;
   logic at_max;
   logic next_at_max;

   // Next values
   logic [7:0] next_count_value;
   logic next_overflow;
   logic [31:0] next_rdata;

   // ************************************************************
   // Bus decode
   // ************************************************************
   // Writes land on the edge where ack is seen high, so one request gives one write
   assign bus_req = wb_cyc_i && wb_stb_i;
   assign wr_en = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];
   assign wr_ctrl = wr_en && hit(wb_adr_i, tw8_pkg::TW8_OFS_CTRL);
   assign wr_count = wr_en && hit(wb_adr_i, tw8_pkg::TW8_OFS_COUNT);
   assign wr_compare = wr_en && hit(wb_adr_i, tw8_pkg::TW8_OFS_COMPARE);
   assign wr_flags = wr_en && hit(wb_adr_i, tw8_pkg::TW8_OFS_FLAGS);
   assign wdat_mode = {wb_dat_i[tw8_pkg::TW8_CTRL_WGM_HI_BIT], wb_dat_i[tw8_pkg::TW8_CTRL_WGM_LO_BIT]}; // see [RULE_21]

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req && !wb_ack_o;
      end
   end

   // Read mux; unmapped offsets read as zero and still ack
   always_comb begin
      next_rdata = tw8_pkg::TW8_READ_ZERO;
      if (hit(wb_adr_i, tw8_pkg::TW8_OFS_CTRL)) begin
         next_rdata[tw8_pkg::TW8_CTRL_WGM_HI_BIT] = ctrl.wave_gen_mode[1];
         next_rdata[tw8_pkg::TW8_CTRL_WGM_LO_BIT] = ctrl.wave_gen_mode[0];
         next_rdata[tw8_pkg::TW8_CTRL_COM_HI_BIT] = ctrl.cmp_out_mode[1];
         next_rdata[tw8_pkg::TW8_CTRL_COM_LO_BIT] = ctrl.cmp_out_mode[0];
      end else if (hit(wb_adr_i, tw8_pkg::TW8_OFS_COUNT)) begin
         next_rdata[7:0] = count_value;
      end else if (hit(wb_adr_i, tw8_pkg::TW8_OFS_COMPARE)) begin
         next_rdata[7:0] = compare_buf;
      end else if (hit(wb_adr_i, tw8_pkg::TW8_OFS_FLAGS)) begin
         next_rdata[tw8_pkg::TW8_FLAG_OVF_BIT] = overflow_flag;
         next_rdata[tw8_pkg::TW8_FLAG_CMP_BIT] = compare_flag;
         next_rdata[tw8_pkg::TW8_FLAG_STATE_BIT] = cmp_out_state;
      end
   end

   // Read data captured with the ack, zero otherwise
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wb_dat_o <= tw8_pkg::TW8_READ_ZERO;
      end else if (bus_req && !wb_ack_o && !wb_we_i) begin
         wb_dat_o <= next_rdata;
      end else begin
         wb_dat_o <= tw8_pkg::TW8_READ_ZERO;
      end
   end

   // ************************************************************
   // Control register
   // ************************************************************
   // Output mode changes take effect at the next match, not retroactively
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl.wave_gen_mode <= tw8_pkg::TW8_WGM_NORMAL;
         ctrl.cmp_out_mode <= tw8_pkg::TW8_COM_OFF;
      end else if (wr_ctrl) begin
         ctrl.wave_gen_mode <= wdat_mode; // see [RULE_21]
         ctrl.cmp_out_mode <= wb_dat_i[tw8_pkg::TW8_CTRL_COM_HI_BIT:tw8_pkg::TW8_CTRL_COM_LO_BIT]; // see [RULE_05]
      end
   end

   // Force strobe is held one cycle so it uses the freshly written output mode
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         force_pending <= 1'b0;
      end else begin
         force_pending <= wr_ctrl && wb_dat_i[tw8_pkg::TW8_CTRL_FORCE_BIT] && !is_pwm(wdat_mode); // see [RULE_05]
      end
   end

   // ************************************************************
   // Compare registers
   // ************************************************************
   // Buffer always takes software writes; reads return it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         compare_buf <= tw8_pkg::TW8_COMPARE_RST;
      end else if (wr_compare) begin
         compare_buf <= wb_dat_i[7:0]; // see [RULE_19]
      end
   end

   // Active compare: direct in non-PWM modes, loaded at top in PWM modes
   // A late low value in clear-on-compare is simply missed until the wrap
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         compare_value <= tw8_pkg::TW8_COMPARE_RST;
      end else if (wr_compare && !is_pwm(ctrl.wave_gen_mode)) begin
         compare_value <= wb_dat_i[7:0]; // see [RULE_11]
      end else if (timer_tick && at_max && is_pwm(ctrl.wave_gen_mode)) begin
         compare_value <= compare_buf; // see [RULE_20]
      end
   end

   // ************************************************************
   // Compare match
   // ************************************************************
   assign at_max = (count_value == tw8_pkg::TW8_MAX);
   assign raw_match = (count_value == compare_value);
   assign match_evt = timer_tick && raw_match && !match_block; // see [RULE_23]

   // Block set by any count write, released by the next tick even if stopped
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         match_block <= 1'b0;
      end else if (wr_count) begin
         match_block <= 1'b1; // see [RULE_23]
      end else if (timer_tick) begin
         match_block <= 1'b0;
      end
   end

   // ************************************************************
   // Counter
   // ************************************************************
   // Only the waveform mode picks the sequence; output mode never enters here
   always_comb begin
      next_count_value = count_value + 8'h01;
      case (ctrl.wave_gen_mode) // see [RULE_06]
         tw8_pkg::TW8_WGM_NORMAL: next_count_value = count_value + 8'h01; // see [RULE_07]
         tw8_pkg::TW8_WGM_PHASE: next_count_value = count_value + 8'h01;
         tw8_pkg::TW8_WGM_CTC: begin
            if (match_evt) begin
               next_count_value = tw8_pkg::TW8_BOTTOM; // see [RULE_10]
            end else begin
               next_count_value = count_value + 8'h01; // see [RULE_11]
            end
         end
         tw8_pkg::TW8_WGM_FAST: begin
            if (at_max) begin
               next_count_value = tw8_pkg::TW8_BOTTOM; // see [RULE_15]
            end else begin
               next_count_value = count_value + 8'h01;
            end
         end
         default: next_count_value = count_value + 8'h01;
      endcase
   end

   // Software write beats any count or clear on the same edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count_value <= tw8_pkg::TW8_COUNT_RST;
      end else if (wr_count) begin
         count_value <= wb_dat_i[7:0]; // see [RULE_09]
      end else if (timer_tick) begin
         count_value <= next_count_value; // see [RULE_24]
      end
   end

   // ************************************************************
   // Flags
   // ************************************************************
   // Overflow point depends on mode; fast PWM flags on reaching MAX
   assign next_at_max = (next_count_value == tw8_pkg::TW8_MAX);
   always_comb begin
      case (ctrl.wave_gen_mode)
         tw8_pkg::TW8_WGM_FAST: next_overflow = timer_tick && !wr_count && next_at_max && !at_max; // see [RULE_17]
         tw8_pkg::TW8_WGM_CTC: next_overflow = timer_tick && !wr_count && at_max; // see [RULE_13]
         default: next_overflow = timer_tick && !wr_count && at_max; // see [RULE_08]
      endcase
   end

   // Write-one-to-clear decode, shared by both flags
   function automatic logic w1c(input int pos);
      w1c = wr_flags && wb_dat_i[pos];
   endfunction : w1c

   // Set beats clear; service and write-one clears are both honoured
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         overflow_flag <= 1'b0;
      end else if (next_overflow) begin
         overflow_flag <= 1'b1; // see [RULE_08]
      end else if (ovf_service_clr || w1c(tw8_pkg::TW8_FLAG_OVF_BIT)) begin
         overflow_flag <= 1'b0;
      end
   end

   // Match seen on the current count is flagged at the tick; force never sets it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         compare_flag <= 1'b0;
      end else if (match_evt) begin
         compare_flag <= 1'b1; // see [RULE_22] see [RULE_14]
      end else if (cmp_service_clr || w1c(tw8_pkg::TW8_FLAG_CMP_BIT)) begin
         compare_flag <= 1'b0;
      end
   end

   // ************************************************************
   // Waveform output
   // ************************************************************
   // Bottom event is the MAX-to-bottom tick in fast PWM
   always_comb begin
      evt = '0;
      evt.match = match_evt;
      evt.bottom = timer_tick && !wr_count && at_max; // see [RULE_16] see [RULE_18]
      evt.force_cmp = force_pending;
   end

   tw8_wave_out u_wave_out (
      .clk(clk),
      .sys_rst(sys_rst),
      .ctrl(ctrl),
      .evt(evt),
      .port_out_value(port_out_value),
      .pin_direction_bit(pin_direction_bit), // see [RULE_03]
      .cmp_out_state(cmp_out_state),
      .pin_out(pin_out),
      .pin_oe(pin_oe)
   );

endmodule : tw8_timer
`default_nettype wire

/* File: dv/tw8_timer_asserts.sv */
// Purpose: Port-level checker for the timer waveform block
// Assumes: One clock domain, synchronous active-high reset
// Notes: Sees only top-level ports; count and compare stay hidden
`timescale 1ns/10ps
`default_nettype none
module tw8_timer_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Stimulus side
   input wire logic timer_tick,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic ovf_service_clr,
   input wire logic port_out_value,
   input wire logic pin_direction_bit,
   // Design outputs
   input wire logic wb_ack_o,
   input wire logic overflow_flag,
   input wire logic compare_flag,
   input wire logic cmp_out_state,
   input wire logic pin_out,
   input wire logic pin_oe
);
   // ************************************************************
   // Properties
   // ************************************************************
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_rst_state:
      assert property ($fell(sys_rst) |-> !cmp_out_state) else $error("state high after reset");
   chk_pin_source:
      assert property (!$past(sys_rst) |-> pin_out == cmp_out_state || pin_out == $past(port_out_value))
      else $error("pin value from wrong source");
   chk_pin_dir:
      assert property (!$past(sys_rst) |-> pin_oe == $past(pin_direction_bit)) else $error("pin enable wrong");
   // Force acts one cycle after the write edge, hence depth two
   chk_state_cause:
      assert property ($changed(cmp_out_state) |-> $past(timer_tick) || $past(wb_ack_o, 2) || $past(sys_rst))
      else $error("state moved without a cause");
   chk_ovf_tick:
      assert property ($rose(overflow_flag) |-> $past(timer_tick)) else $error("overflow set off tick");
   chk_cmp_tick:
      assert property ($rose(compare_flag) |-> $past(timer_tick)) else $error("compare flag set off tick");
   chk_ovf_sticky:
      assert property ($fell(overflow_flag) |-> $past(ovf_service_clr) || $past(wb_ack_o && wb_we_i))
      else $error("overflow cleared by hardware");
   chk_ack_once:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   chk_ack_answer:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
endmodule : tw8_timer_asserts

bind tw8_timer tw8_timer_asserts i_tw8_timer_asserts (
   .clk(clk), .sys_rst(sys_rst), .timer_tick(timer_tick), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .ovf_service_clr(ovf_service_clr), .port_out_value(port_out_value),
   .pin_direction_bit(pin_direction_bit), .wb_ack_o(wb_ack_o), .overflow_flag(overflow_flag),
   .compare_flag(compare_flag), .cmp_out_state(cmp_out_state), .pin_out(pin_out), .pin_oe(pin_oe)
);
`default_nettype wire

/* File: dv/tw8_pin_model.sv */
// Purpose: Port pad seen from outside the device
// Assumes: No pull resistor on the pad
// Notes: An undriven pad toggles each cycle so stale levels never match
`timescale 1ns/10ps
`default_nettype none
module tw8_pin_model (
   // Clock
   input wire logic clk,
   // Device side
   input wire logic pin_out,
   input wire logic pin_oe,
   // Pad
   output logic pad
);
   logic last = 1'b0;

   // Remember the pad so a released line can show its inverse
   always_ff @(posedge clk) begin
      last <= pad;
   end
   assign pad = pin_oe ? pin_out : ~last;
endmodule : tw8_pin_model
`default_nettype wire

/* File: dv/tw8_timer_bench.sv */
// Purpose: Self-checking bench for the timer waveform block
// Assumes: Ticks come only from run, so counts are exact
// Notes: Bus answers are taken at the rising edge that samples ack high
`timescale 1ns/10ps
`default_nettype none
module tw8_timer_bench;
   localparam logic [7:0] A_CTL = tw8_pkg::TW8_OFS_CTRL;
   localparam logic [7:0] A_CNT = tw8_pkg::TW8_OFS_COUNT;
   localparam logic [7:0] A_CMP = tw8_pkg::TW8_OFS_COMPARE;
   localparam logic [7:0] A_FLG = tw8_pkg::TW8_OFS_FLAGS;
   logic clk = 1'b0, sys_rst = 1'b1, timer_tick = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_dat = 32'h0, wb_rd;
   logic ovf_clr = 1'b0, cmp_clr = 1'b0, port_val = 1'b1, dir_bit = 1'b1;
   logic wb_ack, ovf_f, cmp_f, state, pin_out, pin_oe, pad;
   int n_errors = 0;
   int n_compared = 0;

   tw8_timer i_tw8_timer (.clk(clk), .sys_rst(sys_rst), .timer_tick(timer_tick), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .ovf_service_clr(ovf_clr), .cmp_service_clr(cmp_clr),
      .overflow_flag(ovf_f), .compare_flag(cmp_f), .port_out_value(port_val),
      .pin_direction_bit(dir_bit), .cmp_out_state(state), .pin_out(pin_out), .pin_oe(pin_oe));
   tw8_pin_model i_tw8_pin_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic tally_and_finish;
      if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic bit_is(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask : bit_is

   // One classic cycle; the bound stands in for a hung slave
   task automatic wb_io(input logic [7:0] a, input logic we, input logic [31:0] d, output logic [31:0] q);
      int k;
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      wb_sel <= 4'h1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (wb_ack !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_errors++;
         tally_and_finish();
      end
      q = wb_rd;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
   endtask : wb_io

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb_io(a, 1'b1, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb_io(a, 1'b0, 32'h0, q);
      chk(q, exp);
   endtask : rd

   // Exactly n tick edges, then settle past the last one
   task automatic run(input int n);
      @(posedge clk);
      timer_tick <= 1'b1;
      repeat (n) @(posedge clk);
      timer_tick <= 1'b0;
      @(negedge clk);
   endtask : run

   task automatic gap;
      repeat (2) @(negedge clk);
   endtask : gap

   // ************************************************************
   // Stimulus
   // ************************************************************
   initial forever #5 clk = ~clk;

   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      wr(8'h10, 32'hff);
      for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0);
      bit_is(state, 1'b0);
      bit_is(pad, 1'b1);
      // Normal mode wrap, overflow and match at zero
      wr(A_CNT, 32'hfe);
      run(1);
      rd(A_CNT, 32'hff);
      bit_is(ovf_f, 1'b0);
      run(1);
      bit_is(ovf_f, 1'b1);
      bit_is(cmp_f, 1'b0);
      run(1);
      bit_is(cmp_f, 1'b1);
      rd(A_CNT, 32'h01);
      @(posedge clk);
      ovf_clr <= 1'b1;
      cmp_clr <= 1'b1;
      @(posedge clk);
      ovf_clr <= 1'b0;
      cmp_clr <= 1'b0;
      gap;
      chk({30'h0, ovf_f, cmp_f}, 32'h0);
      // Counter write hides the following match
      wr(A_CMP, 32'h10);
      wr(A_CNT, 32'h10);
      run(1);
      bit_is(cmp_f, 1'b0);
      rd(A_CNT, 32'h11);
      wr(A_CNT, 32'h0f);
      run(2);
      bit_is(cmp_f, 1'b1);
      // Clear on compare with toggle
      wr(A_CMP, 32'h03);
      wr(A_CNT, 32'h00);
      wr(A_CTL, 32'h50);
      port_val <= 1'b0;
      rd(A_CTL, 32'h50);
      run(3);
      bit_is(state, 1'b0);
      run(1);
      bit_is(state, 1'b1);
      bit_is(pin_out, 1'b1);
      rd(A_CNT, 32'h00);
      rd(A_FLG, 32'h06);
      dir_bit <= 1'b0;
      gap;
      bit_is(pin_oe, 1'b0);
      @(posedge clk);
      dir_bit <= 1'b1;
      wr(A_CTL, 32'h40);
      run(4);
      bit_is(state, 1'b1);
      bit_is(pin_out, 1'b0);
      rd(A_CNT, 32'h00);
      wr(A_CTL, 32'h50);
      run(3);
      bit_is(state, 1'b1);
      run(1);
      bit_is(state, 1'b0);
      // Compare below count is missed until the wrap
      wr(A_FLG, 32'h03);
      wr(A_CNT, 32'h05);
      run(250);
      rd(A_CNT, 32'hff);
      bit_is(ovf_f, 1'b0);
      run(1);
      bit_is(ovf_f, 1'b1);
      run(4);
      rd(A_CNT, 32'h00);
      bit_is(state, 1'b1);
      // Forced actions: clear, set, toggle
      wr(A_FLG, 32'h03);
      wr(A_CTL, 32'he0);
      gap;
      bit_is(state, 1'b0);
      wr(A_CTL, 32'hf0);
      gap;
      bit_is(state, 1'b1);
      rd(A_CTL, 32'h70);
      wr(A_CTL, 32'hd0);
      gap;
      bit_is(state, 1'b0);
      rd(A_FLG, 32'h00);
      // Fast PWM, non-inverting, buffered compare
      wr(A_CTL, 32'h68);
      wr(A_CMP, 32'h80);
      wr(A_CNT, 32'hfd);
      run(1);
      bit_is(ovf_f, 1'b0);
      run(1);
      bit_is(ovf_f, 1'b1);
      run(1);
      bit_is(state, 1'b1);
      rd(A_CMP, 32'h80);
      wr(A_CMP, 32'h40);
      run(128);
      bit_is(state, 1'b1);
      run(1);
      bit_is(state, 1'b0);
      run(127);
      bit_is(state, 1'b1);
      run(64);
      bit_is(state, 1'b1);
      run(1);
      bit_is(state, 1'b0);
      // Inverting polarity
      wr(A_CTL, 32'h78);
      run(191);
      bit_is(state, 1'b0);
      run(65);
      bit_is(state, 1'b1);
      // Force strobe with a clearing mode is ignored in fast PWM
      wr(A_CTL, 32'he8);
      gap;
      bit_is(state, 1'b1);
      tally_and_finish();
   end
endmodule : tw8_timer_bench
`default_nettype wire
